// [hw/dic_top.v]
// What this block does
// R1: Special role off at 0, on at 1.
// R2: Enable bits: neg limit, pos limit, home, interlock.
// R3: Enable word never affects inputs 16 to 31.
// R4: Invert 0 passes level, 1 reports inverse.
// R5: Invert bit n steers input n plus one.
// R6: Invert ordinary and special inputs, not clock/direction.
// R7: Force bit 1 ignores the physical input.
// R8: Force bit n steers input n plus one.
// R9: Forced input reports its force-value bit.
// R10: Raw word shows unmodified physical inputs.
// R11: Receiver bit 0 single-ended, 1 differential.
// R12: Routing bit 1 enables routing; resets to 1.
// R13: Raw, then inversion, then forcing.
`timescale 1ns/10ps
`include "dic_map.vh"

module dic_top (
   // Clock and reset.
   input  wire        mclk,
   input  wire        rst,
   // Physical digital inputs, input 1 on bit 0.
   input  wire [31:0] din_pin,
   // Configuration object access by subindex.
   input  wire [7:0]  cfg_index,
   input  wire        cfg_wr,
   input  wire        cfg_rd,
   input  wire [31:0] cfg_wdata,
   output wire [31:0] cfg_rdata,
   output wire        cfg_rvalid,
   output wire        cfg_err,
   // Processed inputs and special roles.
   output wire [31:0] din_word,
   output wire        neg_limit,
   output wire        pos_limit,
   output wire        home_switch,
   output wire        interlock,
   // Receiver and routing controls.
   output wire [31:0] range_sel,
   output wire [31:0] diff_sel,
   output wire        routing_on
);

   reg  [31:0] special_role_enable_reg;
   reg  [31:0] input_invert_reg;
   reg  [31:0] force_select_reg;
   reg  [31:0] forced_level_reg;
   reg  [31:0] range_choice_reg;
   reg  [31:0] receiver_type_reg;
   reg  [31:0] routing_switch_reg;
   reg  [31:0] din_word_reg;
   reg  [3:0]  role_reg;
   reg  [31:0] rdata_reg;
   reg         rvalid_reg;
   reg         err_reg;
   reg  [31:0] rdata_next;
   reg         err_next;
   reg  [31:0] proc_next;
   wire [31:0] raw_in;
   wire [31:0] invert_eff;

   // =======================================================================
   // Input synchronisation.
   // =======================================================================
   dic_sync #(
      .WIDTH    (`DIC_WIDTH)
   ) u_sync (
      .mclk     (mclk),
      .rst      (rst),
      .async_in (din_pin),
      .settled  (raw_in)
   );

   // =======================================================================
   // Conditioning pipeline.
   // =======================================================================
   // Clock and direction inputs always keep their physical sense.
   assign invert_eff = input_invert_reg & ~`DIC_CLKDIR_MASK; // R6

   always @* begin
      proc_next = raw_in ^ invert_eff;                                  // R4 R5 R13
      proc_next = (proc_next & ~force_select_reg) |
                  (forced_level_reg & force_select_reg);                // R7 R8 R9 R13
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         din_word_reg <= 32'h0000_0000;
         role_reg     <= 4'h0;
      end else begin
         din_word_reg <= proc_next;
         // Only the low role bits are used, so bits 16 to 31 are untouched.
         role_reg     <= proc_next[3:0] & special_role_enable_reg[3:0];  // R1 R2 R3
      end
   end

   assign din_word    = din_word_reg;
   assign neg_limit   = role_reg[`DIC_BIT_NEG_LIMIT];                   // R2
   assign pos_limit   = role_reg[`DIC_BIT_POS_LIMIT];                   // R2
   assign home_switch = role_reg[`DIC_BIT_HOME];                        // R2
   assign interlock   = role_reg[`DIC_BIT_INTERLOCK];                   // R2

   // =======================================================================
   // Configuration writes.
   // =======================================================================
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         special_role_enable_reg <= `DIC_RST_SPECIAL;
         input_invert_reg        <= `DIC_RST_INVERT;
         force_select_reg        <= `DIC_RST_FORCE_SEL;
         forced_level_reg        <= `DIC_RST_FORCE_LVL;
         range_choice_reg        <= `DIC_RST_RANGE;
         receiver_type_reg       <= `DIC_RST_RECEIVER;
         routing_switch_reg      <= `DIC_RST_ROUTING;                   // R12
      end else if (cfg_wr) begin
         case (cfg_index)
            `DIC_OFS_SPECIAL:   special_role_enable_reg <= cfg_wdata;
            `DIC_OFS_INVERT:    input_invert_reg        <= cfg_wdata;
            `DIC_OFS_FORCE_SEL: force_select_reg        <= cfg_wdata;
            `DIC_OFS_FORCE_LVL: forced_level_reg        <= cfg_wdata;
            `DIC_OFS_RANGE:     range_choice_reg        <= cfg_wdata;
            `DIC_OFS_RECEIVER:  receiver_type_reg       <= cfg_wdata;   // R11
            `DIC_OFS_ROUTING:   routing_switch_reg      <= cfg_wdata;   // R12
            default: begin
            end
         endcase
      end
   end

   assign range_sel  = range_choice_reg;
   assign diff_sel   = receiver_type_reg;                               // R11
   assign routing_on = routing_switch_reg[`DIC_ROUTING_BIT];            // R12

   // =======================================================================
   // Configuration reads, answered one cycle after the strobe.
   // =======================================================================
   always @* begin
      rdata_next = 32'h0000_0000;
      err_next   = 1'b0;
      case (cfg_index)
         `DIC_OFS_COUNT_IDX: rdata_next = {24'h00_0000, `DIC_RST_COUNT};
         `DIC_OFS_SPECIAL:   rdata_next = special_role_enable_reg;
         `DIC_OFS_INVERT:    rdata_next = input_invert_reg;
         `DIC_OFS_FORCE_SEL: rdata_next = force_select_reg;
         `DIC_OFS_FORCE_LVL: rdata_next = forced_level_reg;
         `DIC_OFS_RAW:       rdata_next = raw_in;                       // R10
         `DIC_OFS_RANGE:     rdata_next = range_choice_reg;
         `DIC_OFS_RECEIVER:  rdata_next = receiver_type_reg;
         `DIC_OFS_ROUTING:   rdata_next = routing_switch_reg;
         default:            err_next   = 1'b1;
      endcase
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_reg  <= 32'h0000_0000;
         rvalid_reg <= 1'b0;
         err_reg    <= 1'b0;
      end else begin
         rvalid_reg <= cfg_rd;
         err_reg    <= cfg_rd & err_next;
         if (cfg_rd) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   assign cfg_rdata  = rdata_reg;
   assign cfg_rvalid = rvalid_reg;
   assign cfg_err    = err_reg;

endmodule // dic_top

// [common/dic_map.vh]
`ifndef DIC_MAP_VH
`define DIC_MAP_VH

// ==========================================================================
// Register offsets (subindex numbers).
// ==========================================================================
`define DIC_OFS_COUNT     8'h08
`define DIC_OFS_COUNT_IDX 8'h00
`define DIC_OFS_SPECIAL   8'h01
`define DIC_OFS_INVERT    8'h02
`define DIC_OFS_FORCE_SEL 8'h03
`define DIC_OFS_FORCE_LVL 8'h04
`define DIC_OFS_RAW       8'h05
`define DIC_OFS_RANGE     8'h06
`define DIC_OFS_RECEIVER  8'h07
`define DIC_OFS_ROUTING   8'h08

// ==========================================================================
// Reset values.
// ==========================================================================
`define DIC_RST_COUNT     8'h08
`define DIC_RST_SPECIAL   32'h0000_0000
`define DIC_RST_INVERT    32'h0000_0000
`define DIC_RST_FORCE_SEL 32'h0000_0000
`define DIC_RST_FORCE_LVL 32'h0000_0000
`define DIC_RST_RANGE     32'h0000_0000
`define DIC_RST_RECEIVER  32'h0000_0000
`define DIC_RST_ROUTING   32'h0000_0001

// ==========================================================================
// Field positions and masks.
// ==========================================================================
`define DIC_BIT_NEG_LIMIT 0
`define DIC_BIT_POS_LIMIT 1
`define DIC_BIT_HOME      2
`define DIC_BIT_INTERLOCK 3
`define DIC_SPECIAL_MASK  32'h0000_000F
`define DIC_CLKDIR_MASK   32'h0000_0030
`define DIC_ROUTING_BIT   0
`define DIC_WIDTH         32

`endif

// [hw/dic_sync.v]
`timescale 1ns/10ps

// ==========================================================================
// Three-stage input synchroniser; a change counts once stages two and
// three agree.
// ==========================================================================
module dic_sync #(
   parameter WIDTH = 32
) (
   // Clock and reset.
   input  wire             mclk,
   input  wire             rst,
   // Asynchronous inputs and their settled values.
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] settled
);

   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;
   reg [WIDTH-1:0] stage3_reg;
   reg [WIDTH-1:0] settled_reg;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge mclk or posedge rst) begin
            if (rst) begin
               stage1_reg[i]  <= 1'b0;
               stage2_reg[i]  <= 1'b0;
               stage3_reg[i]  <= 1'b0;
               settled_reg[i] <= 1'b0;
            end else begin
               stage1_reg[i] <= async_in[i];
               stage2_reg[i] <= stage1_reg[i];
               stage3_reg[i] <= stage2_reg[i];
               if (stage2_reg[i] == stage3_reg[i]) begin
                  settled_reg[i] <= stage3_reg[i];
               end
            end
         end
      end
   endgenerate

   assign settled = settled_reg;

endmodule // dic_sync

// [tb/dic_switch_model.sv]
`timescale 1ns/10ps
// ====================================================================
// Switch bank: presents requested levels just after each clock edge.
// ====================================================================
module dic_switch_model (
   input  wire        mclk,
   input  wire [31:0] level_req,
   output reg  [31:0] din_pin
);
   initial din_pin = 32'h0000_0000;
   always @(posedge mclk) din_pin <= #1 level_req;
endmodule // dic_switch_model

// [tb/dic_top_monitor.sv]
`timescale 1ns/10ps
// ====================================================================
// Port checker for the input conditioning block.
// ====================================================================
module dic_top_monitor (
   input wire        mclk,
   input wire        rst,
   input wire [7:0]  cfg_index,
   input wire        cfg_wr,
   input wire        cfg_rd,
   input wire [31:0] cfg_wdata,
   input wire [31:0] cfg_rdata,
   input wire        cfg_rvalid,
   input wire        cfg_err,
   input wire [31:0] din_word,
   input wire        neg_limit,
   input wire        pos_limit,
   input wire        home_switch,
   input wire        interlock,
   input wire [31:0] diff_sel,
   input wire        routing_on
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_read_answer: assert property (cfg_rd |=> cfg_rvalid) else $error("read not answered");
   a_no_stray: assert property (!cfg_rd |=> !cfg_rvalid) else $error("stray read answer");
   a_rdata_hold: assert property (!cfg_rvalid |-> $stable(cfg_rdata)) else $error("read data moved");
   a_count_read: assert property (cfg_rd && cfg_index == 8'h00 |=> cfg_rdata == 32'h0000_0008)
      else $error("entry count wrong");
   a_unmapped_err: assert property (cfg_rd && cfg_index > 8'h08 |=> cfg_err && cfg_rdata == 32'h0000_0000)
      else $error("unmapped read not flagged");
   a_routing_write: assert property (cfg_wr && cfg_index == 8'h08 |=> routing_on == $past(cfg_wdata[0]))
      else $error("routing write lost");
   a_diff_write: assert property (cfg_wr && cfg_index == 8'h07 |=> diff_sel == $past(cfg_wdata))
      else $error("receiver write lost");
   a_neg_role: assert property (neg_limit |-> din_word[0]) else $error("neg role without input");
   a_pos_role: assert property (pos_limit |-> din_word[1]) else $error("pos role without input");
   a_home_role: assert property (home_switch |-> din_word[2]) else $error("home role without input");
   a_lock_role: assert property (interlock |-> din_word[3]) else $error("interlock role without input");
   a_mapped_no_err: assert property (cfg_rd && cfg_index <= 8'h08 |=> !cfg_err) else $error("mapped read flagged");
endmodule // dic_top_monitor
bind dic_top dic_top_monitor u_dic_top_monitor (.mclk(mclk), .rst(rst), .cfg_index(cfg_index),
   .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
   .cfg_err(cfg_err), .din_word(din_word), .neg_limit(neg_limit), .pos_limit(pos_limit),
   .home_switch(home_switch), .interlock(interlock), .diff_sel(diff_sel), .routing_on(routing_on));

// [tb/tb_top.sv]
`timescale 1ns/10ps
// ====================================================================
// Self-checking bench for the input conditioning block.
// ====================================================================
module tb_top;
   reg         mclk, rst, cfg_wr, cfg_rd, re;
   reg  [7:0]  cfg_index;
   reg  [31:0] cfg_wdata, level_req, rv;
   wire [31:0] din_pin, cfg_rdata, din_word, range_sel, diff_sel;
   wire        cfg_rvalid, cfg_err, neg_limit, pos_limit, home_switch, interlock, routing_on;
   integer     err_count = 0, cmp_count = 0, cyc = 0, i;
   dic_switch_model u_dic_switch_model (.mclk(mclk), .level_req(level_req), .din_pin(din_pin));
   dic_top u_dic_top (.mclk(mclk), .rst(rst), .din_pin(din_pin), .cfg_index(cfg_index), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cfg_err(cfg_err),
      .din_word(din_word), .neg_limit(neg_limit), .pos_limit(pos_limit), .home_switch(home_switch),
      .interlock(interlock), .range_sel(range_sel), .diff_sel(diff_sel), .routing_on(routing_on));
   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input [7:0] x, input [31:0] d);
      @(posedge mclk) #1;
      cfg_wr = 1;
      cfg_index = x;
      cfg_wdata = d;
      @(posedge mclk) #1;
      cfg_wr = 0;
   endtask
   task rd(input [7:0] x);
      @(posedge mclk) #1;
      cfg_rd = 1;
      cfg_index = x;
      @(posedge mclk) #1;
      cfg_rd = 0;
      chk("rvalid", 32'h0000_0001, {31'h0, cfg_rvalid});
      rv = cfg_rdata;
      re = cfg_err;
   endtask
   task test_reset;
      for (i = 0; i < 9; i = i + 1) begin
         rd(i);
         chk("reset", (i == 0) ? 32'h0000_0008 : (i == 8) ? 32'h0000_0001 : 32'h0000_0000, rv);
      end
      rd(8'h09);
      chk("unmapped", 32'h0000_0001, {31'h0, re});
      chk("routing", 32'h0000_0001, {31'h0, routing_on});
      $display("test reset done");
   endtask
   task test_regs;
      for (i = 0; i < 9; i = i + 1) wr(i, 32'h5A5A_0000 | i);
      for (i = 0; i < 9; i = i + 1) begin
         rd(i);
         chk("readback", (i == 0) ? 32'h0000_0008 : (i == 5) ? 32'h0000_0000 : 32'h5A5A_0000 | i, rv);
      end
      chk("diff", 32'h5A5A_0007, diff_sel);
      chk("range", 32'h5A5A_0006, range_sel);
      chk("routeoff", 32'h0000_0000, {31'h0, routing_on});
      wr(8'h07, 32'h0000_0000);
      wr(8'h08, 32'h0000_0001);
      $display("test regs done");
   endtask
   task test_path(input [31:0] p, input [31:0] inv, input [31:0] fs, input [31:0] fl, input [31:0] en);
      reg [31:0] e;
      level_req = p;
      wr(8'h01, en);
      wr(8'h02, inv);
      wr(8'h03, fs);
      wr(8'h04, fl);
      repeat (8) @(posedge mclk);
      #1 e = ((p ^ (inv & ~32'h0000_0030)) & ~fs) | (fl & fs);
      chk("din_word", e, din_word);
      chk("roles", {28'h0, e[3:0] & en[3:0]}, {28'h0, interlock, home_switch, pos_limit, neg_limit});
      rd(8'h05);
      chk("raw", p, rv);
      $display("test path done");
   endtask
   initial begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         err_count = err_count + 1;
         end_of_test;
      end
   end
   initial begin
      rst = 1; cfg_wr = 0; cfg_rd = 0; cfg_index = 8'h00; cfg_wdata = 32'h0000_0000; level_req = 32'h0000_0000;
      repeat (10) @(posedge mclk);
      #1 rst = 0;
      test_reset;
      test_regs;
      test_path(32'hA5A5_0F3C, 32'hFFFF_00FF, 32'h0000_F00F, 32'h1234_5678, 32'hFFFF_000B);
      test_path(32'h5A5A_F0C3, 32'h0000_FF30, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0007);
      end_of_test;
   end
endmodule // tb_top
